// File: rtl/pfc_pkg.sv
// Shared constants and types for the port 0 flow control register
package pfc_pkg;

    // Bus and datapath widths
    localparam int unsigned PFC_ADDR_W = 12;
    localparam int unsigned PFC_DATA_W = 32;
    localparam int unsigned PFC_LEVEL_W = 8;

    // Register byte address
    localparam logic [11:0] PFC_FLOW_CTRL_OFFSET = 12'h1a8;

    // Field positions inside the register
    localparam int unsigned PFC_MANUAL_BIT = 0;
    localparam int unsigned PFC_TX_EN_BIT = 1;
    localparam int unsigned PFC_RX_EN_BIT = 2;
    localparam int unsigned PFC_LIVE_TX_BIT = 3;
    localparam int unsigned PFC_LIVE_RX_BIT = 4;
    localparam int unsigned PFC_LIVE_DUP_BIT = 5;
    localparam int unsigned PFC_JAM_BIT = 6;
    localparam int unsigned PFC_DIRECT_BIT = 7;
    localparam int unsigned PFC_FIELD_W = 8;

    // Fixed reset value of the direct FIFO link bit
    localparam logic PFC_DIRECT_RESET = 1'b0;

    // Last settle count; four settle cycles pass before straps are trusted
    localparam logic [1:0] PFC_STRAP_SETTLE_CYCLES = 2'h3;

    // Synchronised pin vector layout
    localparam int unsigned PFC_PIN_W = 8;
    localparam int unsigned PFC_PIN_JAM_STRAP = 0;
    localparam int unsigned PFC_PIN_PAUSE_STRAP = 1;
    localparam int unsigned PFC_PIN_MANUAL_STRAP = 2;
    localparam int unsigned PFC_PIN_HALF_STRAP = 3;
    localparam int unsigned PFC_PIN_ANEG_EN = 4;
    localparam int unsigned PFC_PIN_ANEG_RX = 5;
    localparam int unsigned PFC_PIN_ANEG_TX = 6;
    localparam int unsigned PFC_PIN_LINK_HALF = 7;

    // Writable control fields
    typedef struct packed {
        logic direct;
        logic jam;
        logic rx_en;
        logic tx_en;
        logic manual;
    } pfc_ctrl_s;

    // Resolved live status
    typedef struct packed {
        logic half;
        logic rx;
        logic tx;
    } pfc_live_s;

    // Start-up phases
    typedef enum logic [1:0] {
        PFC_SETTLE,
        PFC_LOAD,
        PFC_RUN
    } pfc_phase_e;

endpackage

// File: rtl/pfc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pfc_sync
    import pfc_pkg::*;
#(
    parameter int unsigned W = PFC_PIN_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins and filtered result
    input wire logic [W-1:0] pin,
    output logic [W-1:0] q
);

    genvar i;

    // One chain per bit; q moves only when stages two and three agree
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic next_q;

            // Stage one feeds stage two only
            always_comb begin
                next_q = q[i];
                if (s2 == s3) begin
                    next_q = s3;
                end
            end

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1 <= pin[i];
                    s2 <= s1;
                    s3 <= s2;
                    q[i] <= next_q;
                end
            end
        end
    endgenerate

endmodule

// File: rtl/pfc_flow_ctrl.sv
// Port 0 flow control configuration and status register
`timescale 1ns/1ps

// Operation
// RULE1 - Direct mode cross-links host and engine FIFO levels
// RULE2 - Software disables other pause methods first
// RULE3 - Bit 6 enables half-duplex jamming
// RULE4 - Bit 5 reports live duplex, 1 half
// RULE5 - Bit 4 reports live receive pause
// RULE6 - Bit 3 reports live transmit pause
// RULE7 - Bit 2 enables pause detection when manual
// RULE8 - Bit 1 enables pause generation when manual
// RULE9 - Manual clear: negotiation governs if enabled
// RULE10 - Manual set: enables alone decide, full duplex
// RULE11 - Writes never touch PHY advertisement
// RULE12 - Writable defaults come from own straps; the direct bit has no strap and loads fixed PFC_DIRECT_RESET
// RULE13 - Status defaults derived from several straps
// RULE14 - Bits 31 to 8 read zero
// RULE15 - Live pause status follows enables combinationally
module pfc_flow_ctrl
    import pfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [PFC_ADDR_W-1:0] addr,
    input wire logic [PFC_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [PFC_DATA_W-1:0] rdata,
    // Configuration strap pins
    input wire logic jam_enable_strap_p0,
    input wire logic pause_enable_strap_p0,
    input wire logic manual_select_strap_p0,
    input wire logic half_duplex_strap_p0,
    // Negotiation and link pins from the PHY side
    input wire logic aneg_enable,
    input wire logic aneg_rx_pause,
    input wire logic aneg_tx_pause,
    input wire logic link_half_duplex,
    // FIFO fill levels, same clock
    input wire logic [PFC_LEVEL_W-1:0] host_rx_fifo_level,
    input wire logic [PFC_LEVEL_W-1:0] engine_rx_fifo_level,
    output logic [PFC_LEVEL_W-1:0] engine_tx_fifo_level,
    output logic [PFC_LEVEL_W-1:0] host_tx_fifo_level,
    // Controls toward the port MAC
    output logic rx_pause_active,
    output logic tx_pause_active,
    output logic jam_active,
    output logic direct_fifo_pause_link_p0,
    output logic straps_loaded
);

    logic [PFC_PIN_W-1:0] pin_raw;
    logic [PFC_PIN_W-1:0] pin_s;
    pfc_phase_e phase;
    pfc_phase_e next_phase;
    logic [1:0] settle_cnt;
    logic [1:0] next_settle_cnt;
    pfc_ctrl_s ctrl;
    pfc_ctrl_s next_ctrl;
    pfc_live_s live;
    pfc_live_s strap_live;
    logic sel_manual_path;
    logic hit;
    logic [PFC_DATA_W-1:0] next_rdata;
    logic [PFC_LEVEL_W-1:0] next_engine_tx;
    logic [PFC_LEVEL_W-1:0] next_host_tx;
    logic next_rx_act;
    logic next_tx_act;
    logic next_jam_act;

    // Gather the outside pins for the synchroniser
    assign pin_raw[PFC_PIN_JAM_STRAP] = jam_enable_strap_p0;
    assign pin_raw[PFC_PIN_PAUSE_STRAP] = pause_enable_strap_p0;
    assign pin_raw[PFC_PIN_MANUAL_STRAP] = manual_select_strap_p0;
    assign pin_raw[PFC_PIN_HALF_STRAP] = half_duplex_strap_p0;
    assign pin_raw[PFC_PIN_ANEG_EN] = aneg_enable;
    assign pin_raw[PFC_PIN_ANEG_RX] = aneg_rx_pause;
    assign pin_raw[PFC_PIN_ANEG_TX] = aneg_tx_pause;
    assign pin_raw[PFC_PIN_LINK_HALF] = link_half_duplex;

    pfc_sync #(
        .W(PFC_PIN_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(pin_raw),
        .q(pin_s)
    );

    // Start-up sequencing; straps are sampled only once settled
    always_comb begin
        next_phase = phase;
        next_settle_cnt = settle_cnt;
        case (phase)
            PFC_SETTLE: begin
                next_settle_cnt = settle_cnt + 2'h1;
                if (settle_cnt == PFC_STRAP_SETTLE_CYCLES) begin
                    next_phase = PFC_LOAD;
                end
            end
            PFC_LOAD: begin
                next_phase = PFC_RUN;
            end
            default: begin
                next_phase = PFC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= PFC_SETTLE;
            settle_cnt <= 2'h0;
        end else begin
            phase <= next_phase;
            settle_cnt <= next_settle_cnt;
        end
    end

    assign hit = (addr == PFC_FLOW_CTRL_OFFSET);

    // Control fields: strap load once, then software writes
    always_comb begin
        next_ctrl = ctrl;
        if (phase == PFC_LOAD) begin
            // RULE12 strap default load
            next_ctrl.jam = pin_s[PFC_PIN_JAM_STRAP];
            next_ctrl.rx_en = pin_s[PFC_PIN_PAUSE_STRAP];
            next_ctrl.tx_en = pin_s[PFC_PIN_PAUSE_STRAP];
            next_ctrl.manual = pin_s[PFC_PIN_MANUAL_STRAP];
            // RULE1 direct link default
            next_ctrl.direct = PFC_DIRECT_RESET;
        end else if (phase == PFC_RUN && wr && hit) begin
            // RULE11 only local fields written
            next_ctrl.direct = wdata[PFC_DIRECT_BIT];
            next_ctrl.jam = wdata[PFC_JAM_BIT];
            next_ctrl.rx_en = wdata[PFC_RX_EN_BIT];
            next_ctrl.tx_en = wdata[PFC_TX_EN_BIT];
            next_ctrl.manual = wdata[PFC_MANUAL_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // RULE13 status defaults from strap mix
    always_comb begin
        strap_live.half = pin_s[PFC_PIN_HALF_STRAP];
        strap_live.rx = pin_s[PFC_PIN_PAUSE_STRAP] &
                        ~pin_s[PFC_PIN_HALF_STRAP];
        strap_live.tx = pin_s[PFC_PIN_PAUSE_STRAP] &
                        ~pin_s[PFC_PIN_HALF_STRAP];
    end

    // RULE9 manual or non-negotiated path select
    assign sel_manual_path = ctrl.manual | ~pin_s[PFC_PIN_ANEG_EN];

    // Pause is a full-duplex feature, so half duplex forces it off
    always_comb begin
        if (phase != PFC_RUN) begin
            live = strap_live;
        end else begin
            // RULE4 duplex follows the link
            live.half = pin_s[PFC_PIN_LINK_HALF];
            // RULE15 combinational resolution
            if (sel_manual_path) begin
                // RULE10 enables alone decide
                live.rx = ctrl.rx_en & ~live.half;
                live.tx = ctrl.tx_en & ~live.half;
            end else begin
                live.rx = pin_s[PFC_PIN_ANEG_RX] & ~live.half;
                live.tx = pin_s[PFC_PIN_ANEG_TX] & ~live.half;
            end
        end
    end

    // Readback assembly; unmapped or idle cycles give zero
    always_comb begin
        next_rdata = '0;
        if (rd && hit) begin
            next_rdata[PFC_DIRECT_BIT] = ctrl.direct;
            next_rdata[PFC_JAM_BIT] = ctrl.jam;
            next_rdata[PFC_LIVE_DUP_BIT] = live.half;
            // RULE5 live receive pause
            next_rdata[PFC_LIVE_RX_BIT] = live.rx;
            // RULE6 live transmit pause
            next_rdata[PFC_LIVE_TX_BIT] = live.tx;
            next_rdata[PFC_RX_EN_BIT] = ctrl.rx_en;
            next_rdata[PFC_TX_EN_BIT] = ctrl.tx_en;
            next_rdata[PFC_MANUAL_BIT] = ctrl.manual;
            // RULE14 upper bits stay zero
            next_rdata[PFC_DATA_W-1:PFC_FIELD_W] = '0;
        end
    end

    // MAC controls and direct FIFO routing
    always_comb begin
        // RULE7 receive pause enable
        next_rx_act = live.rx;
        // RULE8 transmit pause enable
        next_tx_act = live.tx;
        // RULE3 jam only in half duplex
        next_jam_act = ctrl.jam & live.half & (phase == PFC_RUN);
        next_engine_tx = '0;
        next_host_tx = '0;
        // RULE1 cross-link fill levels
        if (ctrl.direct) begin
            next_engine_tx = host_rx_fifo_level;
            next_host_tx = engine_rx_fifo_level;
        end
        // RULE2 other methods forced off while direct is set
        if (ctrl.direct) begin
            next_rx_act = 1'b0;
            next_tx_act = 1'b0;
            next_jam_act = 1'b0;
        end
    end

    // Data outputs all leave from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
            engine_tx_fifo_level <= '0;
            host_tx_fifo_level <= '0;
            rx_pause_active <= 1'b0;
            tx_pause_active <= 1'b0;
            jam_active <= 1'b0;
        end else begin
            rdata <= next_rdata;
            engine_tx_fifo_level <= next_engine_tx;
            host_tx_fifo_level <= next_host_tx;
            rx_pause_active <= next_rx_act;
            tx_pause_active <= next_tx_act;
            jam_active <= next_jam_act;
        end
    end

    assign direct_fifo_pause_link_p0 = ctrl.direct;
    assign straps_loaded = (phase == PFC_RUN);

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_DIRECT_ROUTE: assert property ( // RULE1
        ctrl.direct |=> host_tx_fifo_level == $past(engine_rx_fifo_level)
            && engine_tx_fifo_level == $past(host_rx_fifo_level))
        else $error("direct mode levels not routed");
    AST_DIRECT_LOAD: assert property ( // RULE1
        phase == PFC_LOAD |=> !direct_fifo_pause_link_p0
            ##1 engine_tx_fifo_level == '0 && host_tx_fifo_level == '0)
        else $error("direct link bit not cleared at load");
    AST_JAM_WRITE: assert property ( // RULE3
        phase == PFC_RUN && wr && hit && !wdata[PFC_DIRECT_BIT]
            && pin_s[PFC_PIN_LINK_HALF] ##1 !wr && $stable(pin_s)
            |=> jam_active == $past(wdata[PFC_JAM_BIT], 2))
        else $error("jam output does not follow write");
    AST_DUPLEX_READ: assert property ( // RULE4
        rd && hit && phase == PFC_RUN
            |=> rdata[PFC_LIVE_DUP_BIT] == $past(pin_s[PFC_PIN_LINK_HALF]))
        else $error("duplex readback wrong");
    AST_MANUAL_RX: assert property ( // RULE10
        phase == PFC_RUN && ctrl.manual && !pin_s[PFC_PIN_LINK_HALF]
            |-> live.rx == ctrl.rx_en && live.tx == ctrl.tx_en)
        else $error("manual pause status not taken from enables");
    AST_NEGOTIATED: assert property ( // RULE9
        phase == PFC_RUN && !ctrl.manual && pin_s[PFC_PIN_ANEG_EN]
            |-> live.rx == (pin_s[PFC_PIN_ANEG_RX] & ~live.half)
            && live.tx == (pin_s[PFC_PIN_ANEG_TX] & ~live.half))
        else $error("negotiated pause not applied");
    AST_STRAP_LOAD: assert property ( // RULE12
        phase == PFC_LOAD |=> ctrl.jam == $past(pin_s[PFC_PIN_JAM_STRAP])
            && ctrl.manual == $past(pin_s[PFC_PIN_MANUAL_STRAP])
            && ctrl.rx_en == $past(pin_s[PFC_PIN_PAUSE_STRAP]))
        else $error("strap defaults not loaded");
    AST_STRAP_STATUS: assert property ( // RULE13
        phase != PFC_RUN |-> live.half == pin_s[PFC_PIN_HALF_STRAP]
            && live.rx == (pin_s[PFC_PIN_PAUSE_STRAP]
            & ~pin_s[PFC_PIN_HALF_STRAP]))
        else $error("status default not from straps");
    AST_RESERVED: assert property ( // RULE14
        rd |=> rdata[PFC_DATA_W-1:PFC_FIELD_W] == '0)
        else $error("reserved bits not zero");
    AST_PAUSE_OUT: assert property ( // RULE15
        phase == PFC_RUN && !ctrl.direct |=> rx_pause_active == $past(live.rx)
            && tx_pause_active == $past(live.tx))
        else $error("pause outputs lag the resolution");

    COV_DIRECT: cover property (wr && hit && wdata[PFC_DIRECT_BIT]
        ##1 ctrl.direct);
    COV_NEGOTIATED: cover property (phase == PFC_RUN && !sel_manual_path
        && live.rx);
    COV_JAM: cover property (jam_active);
    COV_READ: cover property (rd && hit ##1 rdata[PFC_LIVE_TX_BIT]);

endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the port 0 flow control register
`timescale 1ns/1ps
module tb_top;
    import pfc_pkg::*;

    // One table row: pins, written byte, expected readback and outputs
    typedef struct packed {
        logic [7:0] wd;
        logic ae, ar, at, hd;
        logic [7:0] ex;
        logic erx, etx, ejam;
    } pfc_row_s;

    logic clk, resetn, wr, rd;
    logic [PFC_ADDR_W-1:0] addr;
    logic [PFC_DATA_W-1:0] wdata, rdata, got;
    logic jam_s, pause_s, man_s, half_s;
    logic aneg_en, aneg_rx, aneg_tx, link_half;
    logic [PFC_LEVEL_W-1:0] host_rx, eng_rx, eng_tx, host_tx;
    logic rx_act, tx_act, jam_act, direct, loaded;
    int n_mismatch, n_tests;
    pfc_row_s rows [6] = '{
        '{8'h3f, 1'b0, 1'b0, 1'b0, 1'b0, 8'h1f, 1'b1, 1'b1, 1'b0},
        '{8'h06, 1'b1, 1'b0, 1'b1, 1'b0, 8'h0e, 1'b0, 1'b1, 1'b0},
        '{8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 8'h10, 1'b1, 1'b0, 1'b0},
        '{8'h04, 1'b0, 1'b1, 1'b1, 1'b0, 8'h14, 1'b1, 1'b0, 1'b0},
        '{8'h41, 1'b0, 1'b0, 1'b0, 1'b1, 8'h61, 1'b0, 1'b0, 1'b1},
        '{8'h7b, 1'b0, 1'b0, 1'b0, 1'b0, 8'h4b, 1'b0, 1'b1, 1'b0}
    };

    pfc_flow_ctrl dut_u (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata),
        .jam_enable_strap_p0(jam_s), .pause_enable_strap_p0(pause_s),
        .manual_select_strap_p0(man_s), .half_duplex_strap_p0(half_s),
        .aneg_enable(aneg_en), .aneg_rx_pause(aneg_rx),
        .aneg_tx_pause(aneg_tx), .link_half_duplex(link_half),
        .host_rx_fifo_level(host_rx), .engine_rx_fifo_level(eng_rx),
        .engine_tx_fifo_level(eng_tx), .host_tx_fifo_level(host_tx),
        .rx_pause_active(rx_act), .tx_pause_active(tx_act),
        .jam_active(jam_act), .direct_fifo_pause_link_p0(direct),
        .straps_loaded(loaded)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Verdict and end of run, reached from every path
    task automatic end_sim();
        $display("counts: %0d mismatches, %0d comparisons",
            n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Single-cycle write, entered right after a rising edge
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data are taken mid-cycle, in the one cycle they stand
    task automatic bus_rd(input logic [11:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        got = rdata;
        @(posedge clk);
    endtask

    // Bounded wait for start-up; straps must be stable until then
    task automatic wait_loaded();
        int i;
        for (i = 0; i < 50 && loaded !== 1'b1; i++) @(posedge clk);
        if (loaded !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // Watchdog against a hang anywhere
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        {wr, rd, addr, wdata} = '0;
        {jam_s, pause_s, man_s, half_s} = 4'b1110;
        {aneg_en, aneg_rx, aneg_tx, link_half} = 4'b0000;
        host_rx = 8'h00;
        eng_rx = 8'h00;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        wait_loaded();
        repeat (6) @(posedge clk);
        bus_rd(PFC_FLOW_CTRL_OFFSET);
        chk(got, 32'h5f);
        chk({29'h0, rx_act, tx_act, jam_act}, 32'h6);

        // Table of control and negotiation combinations
        foreach (rows[k]) begin
            aneg_en <= rows[k].ae;
            aneg_rx <= rows[k].ar;
            aneg_tx <= rows[k].at;
            link_half <= rows[k].hd;
            // Let the pins pass the synchroniser before the write
            repeat (6) @(posedge clk);
            bus_wr(PFC_FLOW_CTRL_OFFSET, {24'hffffff, rows[k].wd});
            repeat (8) @(posedge clk);
            bus_rd(PFC_FLOW_CTRL_OFFSET);
            chk(got, {24'h0, rows[k].ex});
            chk({29'h0, rx_act, tx_act, jam_act},
                {29'h0, rows[k].erx, rows[k].etx, rows[k].ejam});
        end

        // direct mode entered with other methods off
        aneg_en <= 1'b0;
        link_half <= 1'b0;
        bus_wr(PFC_FLOW_CTRL_OFFSET, 32'h81);
        repeat (8) @(posedge clk);
        host_rx <= 8'h5a;
        eng_rx <= 8'ha5;
        @(posedge clk);
        host_rx <= 8'h3c;
        @(negedge clk);
        chk({16'h0, eng_tx, host_tx}, 32'h5aa5);
        @(posedge clk);
        @(negedge clk);
        chk({16'h0, eng_tx, host_tx}, 32'h3ca5);
        chk({28'h0, direct, rx_act, tx_act, jam_act}, 32'h8);
        @(posedge clk);
        bus_wr(PFC_FLOW_CTRL_OFFSET, 32'h00);
        repeat (3) @(posedge clk);
        chk({15'h0, direct, eng_tx, host_tx}, 32'h0);

        // Unmapped write ignored, unmapped read zero, zero after read
        bus_wr(12'h1ac, 32'h47);
        bus_rd(12'h1ac);
        chk(got, 32'h0);
        bus_rd(PFC_FLOW_CTRL_OFFSET);
        chk(got, 32'h0);
        @(negedge clk);
        chk(rdata, 32'h0);

        // Mid-run reset with new straps; early write must be dropped
        @(posedge clk);
        resetn <= 1'b0;
        {jam_s, pause_s, man_s, half_s} <= 4'b0101;
        repeat (3) @(posedge clk);
        chk({29'h0, rx_act, loaded, direct}, 32'h0);
        resetn <= 1'b1;
        @(posedge clk);
        bus_wr(PFC_FLOW_CTRL_OFFSET, 32'h41);
        // Read in the load cycle: status bits still come from the straps
        repeat (2) @(posedge clk);
        bus_rd(PFC_FLOW_CTRL_OFFSET);
        chk(got, 32'h20);
        wait_loaded();
        repeat (6) @(posedge clk);
        bus_rd(PFC_FLOW_CTRL_OFFSET);
        chk(got, 32'h1e);
        end_sim();
    end
endmodule
